// ---- src/lpm_pkg.sv ----
package lpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned FS_FILTER_MS = 100; // Fail-safe dwell filter, ms
  localparam int unsigned OT_DELAY_MS = 1000; // Overtemp restart delay, ms
  localparam int unsigned FS_FILTER_CYC = CLK_HZ / 1000 * FS_FILTER_MS;
  localparam int unsigned OT_DELAY_CYC = CLK_HZ / 1000 * OT_DELAY_MS;
  localparam int TMR_W = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and bit positions
  localparam int WK_N = 3;
  localparam int SRC_N = 4;
  localparam int SRC_CAN = 0;
  localparam int SRC_WK = 1;
  localparam int SRC_LS = 2;
  localparam int SRC_OV = 3;
  localparam int SYNC_W = 7;
  localparam int SY_CAN = 0;
  localparam int SY_WK = 1;
  localparam int SY_LS = 4;
  localparam int SY_OV = 5;
  localparam int SY_OT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FS
  } lpm_mode_e;

  typedef enum logic [1:0] {
    CAN_OFF,
    CAN_WAKE_CAP,
    CAN_ACTIVE,
    CAN_WOKEN
  } lpm_can_e;

  typedef enum logic [1:0] {
    REG_OFF,
    REG_LOW_POWER,
    REG_ON
  } lpm_reg_e;

  typedef enum logic [2:0] {
    CMD_NORMAL,
    CMD_STOP,
    CMD_SLEEP,
    CMD_SOFT_RESET,
    CMD_WD_REFRESH,
    CMD_STATUS_CLR,
    CMD_CFG_WRITE
  } lpm_cmd_e;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic wd_en;
    logic hs_en;
    logic bd_en;
    logic cp_en;
    logic csa_en;
    lpm_can_e can_mode;
    logic cyc_sense_en;
    logic cyc_wake_en;
    logic [WK_N-1:0] wk_wake_en;
  } lpm_cfg_s;

  localparam lpm_cfg_s CFG_RESET = '{can_mode: CAN_OFF, default: '0};

  typedef struct packed {
    lpm_reg_e main_regulator;
    logic wd_en;
    logic hs_en;
    logic bd_en;
    logic cp_en;
    logic csa_en;
    lpm_can_e can_mode;
    logic cyc_sense_en;
    logic cyc_wake_en;
    logic can_wake_src;
    logic [WK_N-1:0] wk_wake_src;
  } lpm_func_s;

endpackage

// ---- src/lpm_sync.sv ----
`timescale 1ns/1ps
module lpm_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// ---- src/lpm_timer.sv ----
`timescale 1ns/1ps
module lpm_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic done_o
);

  localparam logic [lpm_pkg::TMR_W-1:0] LAST = LIMIT[lpm_pkg::TMR_W-1:0] - 1'b1;

  logic [lpm_pkg::TMR_W-1:0] count;

  // Counts while run is high, done holds until run drops
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !run_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else if (count == LAST) begin
      done_o <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule

// ---- src/lpm_mode_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Stop discards SPI writes and flags failure, except normal, soft reset, watchdog, status.
// - Stop wake events may pull interrupt low per mask, mode stays Stop.
// - Stop: regulator low power; watchdog, switches, CAN, cyclic frozen; drivers, pump, amp off.
// - Stop still allows bridge low sides for parking braking; the overvoltage brake input is only a wake source.
// - Sleep: regulator, watchdog, drivers, pump, amp off; switches and cyclic frozen.
// - Sleep sets CAN wake capable, or off if it was configured off.
// - Sleep still allows bridge low sides for braking.
// - Restart holds reset output low while regulator is on or ramping.
// - Restart disables watchdog, switches, cyclic functions; drivers, pump, amp stay off.
// - Restart shows CAN woken after bus wake, else wake capable or off.
// - Fail-safe switches off regulator, watchdog, switches, drivers, pump, amp, cyclic.
// - Fail-safe forces CAN wake capable.
// - Fail-safe entry enables default wake sources and clears wake event bits.
// - Fail-safe holds until a wake on a default wake source, or until the overtemp restart delay ends.
// - Fail-safe dwell filter 100 ms; wakes during it are stored, then restart.
// - Overtemp fail-safe restarts 1 s after temperature falls, no wake needed.
// - Parking braking disabled in fail-safe.
// - Sleep request from Stop flags SPI failure and enters Restart.
// - Stop entry with uncleared wake flags raises interrupt.
module lpm_mode_ctrl #(
  parameter int unsigned FS_FILTER_CYC = lpm_pkg::FS_FILTER_CYC,
  parameter int unsigned OT_DELAY_CYC = lpm_pkg::OT_DELAY_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic spi_wr_valid_i,
  input wire lpm_pkg::lpm_cmd_e spi_wr_kind_i,
  output logic spi_wr_accept_o,
  output logic spi_fail_set_o,
  input wire lpm_pkg::lpm_cfg_s cfg_i,
  input wire logic park_brake_i,
  input wire logic fail_i,
  input wire logic restart_req_i,
  input wire logic restart_done_i,
  input wire logic can_wake_i,
  input wire logic [lpm_pkg::WK_N-1:0] wake_inputs_i,
  input wire logic ls_short_i,
  input wire logic ov_brake_i,
  input wire logic regulator_overtemp_shutdown_i,
  input wire logic [lpm_pkg::SRC_N-1:0] int_mask_i,
  input wire logic wake_flags_pending_i,
  output logic wake_flags_clr_o,
  output lpm_pkg::lpm_mode_e mode_o,
  output lpm_pkg::lpm_func_s func_o,
  output logic ls_brake_o,
  output logic reset_out_n_o,
  output logic int_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  lpm_pkg::lpm_mode_e mode;
  lpm_pkg::lpm_mode_e next_mode;
  lpm_pkg::lpm_cfg_s cfg_hold;
  logic [lpm_pkg::SYNC_W-1:0] pins_s;
  logic can_s;
  logic [lpm_pkg::WK_N-1:0] wk_s;
  logic ot_s;
  logic [lpm_pkg::SRC_N-1:0] wake_vec;
  logic [lpm_pkg::SRC_N-1:0] wake_prev;
  logic [lpm_pkg::SRC_N-1:0] wake_evt;
  logic wake_any;
  logic fs_wake_now;
  logic fs_wake_seen;
  logic ot_cause;
  logic can_woken;
  logic filt_done;
  logic ot_done;
  logic exempt;
  logic in_normal;
  logic in_stop;
  logic in_sleep;
  logic in_restart;
  logic in_fs;
  logic entering_fs;
  logic entering_restart;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  lpm_sync #(
    .W(lpm_pkg::SYNC_W)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i({regulator_overtemp_shutdown_i, ov_brake_i, ls_short_i, wake_inputs_i, can_wake_i}),
    .q_o(pins_s)
  );

  // Decoded sources
  assign can_s = pins_s[lpm_pkg::SY_CAN];
  assign wk_s = pins_s[lpm_pkg::SY_WK +: lpm_pkg::WK_N];
  assign ot_s = pins_s[lpm_pkg::SY_OT];
  assign wake_vec[lpm_pkg::SRC_CAN] = can_s;
  assign wake_vec[lpm_pkg::SRC_WK] = |(wk_s & cfg_hold.wk_wake_en);
  assign wake_vec[lpm_pkg::SRC_LS] = pins_s[lpm_pkg::SY_LS];
  assign wake_vec[lpm_pkg::SRC_OV] = pins_s[lpm_pkg::SY_OV];
  assign wake_evt = wake_vec & ~wake_prev;
  assign wake_any = |wake_vec;
  assign fs_wake_now = can_s | wake_vec[lpm_pkg::SRC_WK];

  // Mode shorthands
  assign in_normal = (mode == lpm_pkg::MODE_NORMAL);
  assign in_stop = (mode == lpm_pkg::MODE_STOP);
  assign in_sleep = (mode == lpm_pkg::MODE_SLEEP);
  assign in_restart = (mode == lpm_pkg::MODE_RESTART);
  assign in_fs = (mode == lpm_pkg::MODE_FS);
  assign entering_fs = !in_fs && (next_mode == lpm_pkg::MODE_FS);
  assign entering_restart = !in_restart && (next_mode == lpm_pkg::MODE_RESTART);
  assign mode_o = mode;

  ////////////////////////////////////////////////////////////////////////////
  // Fail-safe timers
  lpm_timer #(
    .LIMIT(FS_FILTER_CYC)
  ) u_fs_filter (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(in_fs),
    .done_o(filt_done)
  );

  lpm_timer #(
    .LIMIT(OT_DELAY_CYC)
  ) u_ot_delay (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(in_fs && ot_cause && !ot_s),
    .done_o(ot_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // SPI write filter and mode selection
  always_comb begin
    exempt = (spi_wr_kind_i == lpm_pkg::CMD_NORMAL) || (spi_wr_kind_i == lpm_pkg::CMD_SOFT_RESET) ||
             (spi_wr_kind_i == lpm_pkg::CMD_WD_REFRESH) || (spi_wr_kind_i == lpm_pkg::CMD_STATUS_CLR);
    spi_wr_accept_o = spi_wr_valid_i && (!in_stop || exempt);
    spi_fail_set_o = spi_wr_valid_i && in_stop && !exempt;
    next_mode = mode;
    unique case (mode)
      lpm_pkg::MODE_NORMAL: begin
        if (spi_wr_valid_i && spi_wr_kind_i == lpm_pkg::CMD_STOP) begin
          next_mode = lpm_pkg::MODE_STOP;
        end else if (spi_wr_valid_i && spi_wr_kind_i == lpm_pkg::CMD_SLEEP) begin
          next_mode = lpm_pkg::MODE_SLEEP;
        end
      end
      lpm_pkg::MODE_STOP: begin
        // Wake events alone never leave Stop
        if (spi_wr_valid_i && spi_wr_kind_i == lpm_pkg::CMD_NORMAL) begin
          next_mode = lpm_pkg::MODE_NORMAL;
        end else if (spi_wr_valid_i && spi_wr_kind_i == lpm_pkg::CMD_SLEEP) begin
          next_mode = lpm_pkg::MODE_RESTART;
        end
      end
      lpm_pkg::MODE_SLEEP: begin
        if (wake_any) begin
          next_mode = lpm_pkg::MODE_RESTART;
        end
      end
      lpm_pkg::MODE_RESTART: begin
        if (restart_done_i) begin
          next_mode = lpm_pkg::MODE_NORMAL;
        end
      end
      lpm_pkg::MODE_FS: begin
        // Stored or live default-source wake after the dwell filter
        if (filt_done && (fs_wake_seen || fs_wake_now)) begin
          next_mode = lpm_pkg::MODE_RESTART;
        end else if (ot_cause && ot_done) begin
          next_mode = lpm_pkg::MODE_RESTART;
        end
      end
      default: begin
        next_mode = lpm_pkg::MODE_RESTART;
      end
    endcase
    // Faults override everything
    if (fail_i || ot_s) begin
      next_mode = lpm_pkg::MODE_FS;
    end else if (restart_req_i && !in_fs) begin
      next_mode = lpm_pkg::MODE_RESTART;
    end
  end

  // Mode register, reset into Restart
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode <= lpm_pkg::MODE_RESTART;
    end else begin
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration frozen at the last Normal cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_hold <= lpm_pkg::CFG_RESET;
    end else if (in_normal) begin
      cfg_hold <= cfg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fail-safe bookkeeping
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !in_fs) begin
      fs_wake_seen <= 1'b0;
    end else if (fs_wake_now) begin
      fs_wake_seen <= 1'b1;
    end
  end

  // Overtemperature cause of the current fail-safe stay
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ot_cause <= 1'b0;
    end else if (entering_fs) begin
      ot_cause <= ot_s;
    end else if (!in_fs) begin
      ot_cause <= 1'b0;
    end
  end

  // Wake flag clear pulse in the first fail-safe cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_flags_clr_o <= 1'b0;
    end else begin
      wake_flags_clr_o <= entering_fs;
    end
  end

  // CAN woken marker for Restart
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      can_woken <= 1'b0;
    end else if (entering_restart || in_restart) begin
      can_woken <= (can_woken && in_restart) || can_s;
    end else begin
      can_woken <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_prev <= '0;
      int_n_o <= 1'b1;
    end else begin
      wake_prev <= wake_vec;
      int_n_o <= !((in_stop && |(wake_evt & ~int_mask_i)) ||
                   (in_normal && next_mode == lpm_pkg::MODE_STOP && wake_flags_pending_i));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-mode function enables
  always_comb begin
    func_o = '0;
    func_o.main_regulator = lpm_pkg::REG_OFF;
    func_o.can_mode = lpm_pkg::CAN_OFF;
    unique case (mode)
      lpm_pkg::MODE_NORMAL: begin
        func_o.main_regulator = lpm_pkg::REG_ON;
        func_o.wd_en = cfg_i.wd_en;
        func_o.hs_en = cfg_i.hs_en;
        func_o.bd_en = cfg_i.bd_en;
        func_o.cp_en = cfg_i.cp_en;
        func_o.csa_en = cfg_i.csa_en;
        func_o.can_mode = cfg_i.can_mode;
        func_o.cyc_sense_en = cfg_i.cyc_sense_en;
        func_o.cyc_wake_en = cfg_i.cyc_wake_en;
        func_o.wk_wake_src = cfg_i.wk_wake_en;
      end
      lpm_pkg::MODE_STOP: begin
        func_o.main_regulator = lpm_pkg::REG_LOW_POWER;
        func_o.wd_en = cfg_hold.wd_en;
        func_o.hs_en = cfg_hold.hs_en;
        func_o.can_mode = cfg_hold.can_mode;
        func_o.cyc_sense_en = cfg_hold.cyc_sense_en;
        func_o.cyc_wake_en = cfg_hold.cyc_wake_en;
        func_o.wk_wake_src = cfg_hold.wk_wake_en;
      end
      lpm_pkg::MODE_SLEEP: begin
        func_o.hs_en = cfg_hold.hs_en;
        func_o.cyc_sense_en = cfg_hold.cyc_sense_en;
        func_o.cyc_wake_en = cfg_hold.cyc_wake_en;
        func_o.can_mode = (cfg_hold.can_mode == lpm_pkg::CAN_OFF) ? lpm_pkg::CAN_OFF : lpm_pkg::CAN_WAKE_CAP;
        func_o.wk_wake_src = cfg_hold.wk_wake_en;
      end
      lpm_pkg::MODE_RESTART: begin
        func_o.main_regulator = lpm_pkg::REG_ON;
        if (can_woken) begin
          func_o.can_mode = lpm_pkg::CAN_WOKEN;
        end else if (cfg_hold.can_mode != lpm_pkg::CAN_OFF) begin
          func_o.can_mode = lpm_pkg::CAN_WAKE_CAP;
        end
      end
      lpm_pkg::MODE_FS: begin
        func_o.can_mode = lpm_pkg::CAN_WAKE_CAP;
        func_o.wk_wake_src = cfg_hold.wk_wake_en;
      end
      default: begin
        func_o.main_regulator = lpm_pkg::REG_ON;
      end
    endcase
    func_o.can_wake_src = in_fs || (func_o.can_mode != lpm_pkg::CAN_OFF);
  end

  // Low-side braking allowed outside fail-safe
  assign ls_brake_o = park_brake_i && !in_fs;
  assign reset_out_n_o = !in_restart;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_stop_cfg_write;
    in_stop && spi_wr_valid_i && spi_wr_kind_i == lpm_pkg::CMD_CFG_WRITE;
  endsequence

  sequence s_stop_sleep_cmd;
    in_stop && spi_wr_valid_i && spi_wr_kind_i == lpm_pkg::CMD_SLEEP && !fail_i && !ot_s && !restart_req_i;
  endsequence

  sequence s_fs_entry;
    !in_fs ##1 in_fs;
  endsequence

  stop_spi_filter_a: assert property (s_stop_cfg_write |-> !spi_wr_accept_o && spi_fail_set_o)
    else $error("config write accepted in stop");

  stop_wake_hold_a: assert property (in_stop && !spi_wr_valid_i && !fail_i && !ot_s && !restart_req_i
    |=> in_stop)
    else $error("stop left without command");

  stop_outputs_a: assert property (in_stop |-> func_o.main_regulator == lpm_pkg::REG_LOW_POWER &&
    !func_o.bd_en && !func_o.cp_en && !func_o.csa_en && func_o.wd_en == cfg_hold.wd_en)
    else $error("stop enables wrong");

  sleep_outputs_a: assert property (in_sleep |-> func_o.main_regulator == lpm_pkg::REG_OFF &&
    !func_o.wd_en && !func_o.bd_en && func_o.hs_en == cfg_hold.hs_en)
    else $error("sleep enables wrong");

  restart_reset_a: assert property (in_restart |-> !reset_out_n_o && !func_o.wd_en && !func_o.hs_en)
    else $error("restart outputs wrong");

  fs_outputs_a: assert property (in_fs |-> func_o.main_regulator == lpm_pkg::REG_OFF &&
    func_o.can_mode == lpm_pkg::CAN_WAKE_CAP && !ls_brake_o)
    else $error("fail-safe outputs wrong");

  fs_entry_clear_a: assert property (s_fs_entry |-> wake_flags_clr_o && func_o.can_wake_src)
    else $error("fail-safe entry without clear");

  fs_filter_hold_a: assert property (in_fs && !filt_done && !restart_req_i |=> in_fs)
    else $error("fail-safe left inside filter");

  stop_sleep_req_a: assert property (s_stop_sleep_cmd |-> spi_fail_set_o ##1 in_restart)
    else $error("sleep from stop not diverted");

  stop_entry_int_a: assert property (in_normal && next_mode == lpm_pkg::MODE_STOP && wake_flags_pending_i
    |=> !int_n_o && in_stop)
    else $error("stop entry interrupt missing");

endmodule

// ---- test/lpm_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host model: issues decoded SPI writes and holds the live configuration
module lpm_host (
  input wire logic sys_clk_i,
  input wire logic spi_wr_accept_i,
  input wire logic spi_fail_set_i,
  output logic spi_wr_valid_o,
  output lpm_pkg::lpm_cmd_e spi_wr_kind_o,
  output lpm_pkg::lpm_cfg_s cfg_o
);
  logic last_accept;
  logic last_fail;

  // Idle bus and empty configuration at time zero
  initial begin
    spi_wr_valid_o = 1'b0;
    spi_wr_kind_o = lpm_pkg::CMD_WD_REFRESH;
    cfg_o = '0;
    last_accept = 1'b0;
    last_fail = 1'b0;
  end

  // Configuration is only changed before a low-power command is sent
  task configure(input lpm_pkg::lpm_cfg_s c);
    @(posedge sys_clk_i);
    #10;
    cfg_o = c;
  endtask

  // One-cycle write; answer taken at the edge that applies it
  task send(input lpm_pkg::lpm_cmd_e k);
    @(posedge sys_clk_i);
    #10;
    spi_wr_valid_o = 1'b1;
    spi_wr_kind_o = k;
    @(posedge sys_clk_i);
    last_accept = spi_wr_accept_i;
    last_fail = spi_fail_set_i;
    #10;
    spi_wr_valid_o = 1'b0;
  endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic spi_wr_valid_i;
  lpm_pkg::lpm_cmd_e spi_wr_kind_i;
  logic spi_wr_accept_o;
  logic spi_fail_set_o;
  lpm_pkg::lpm_cfg_s cfg_i;
  logic park_brake_i = 1'b0;
  logic fail_i = 1'b0;
  logic restart_done_i = 1'b0;
  logic [3:0] src = 4'h0;
  logic overtemp = 1'b0;
  logic [3:0] int_mask_i = 4'h0;
  logic wake_flags_pending_i = 1'b0;
  logic wake_flags_clr_o;
  lpm_pkg::lpm_mode_e mode_o;
  lpm_pkg::lpm_func_s func_o;
  logic ls_brake_o;
  logic reset_out_n_o;
  logic int_n_o;
  int err_count = 0;
  int cmp_count = 0;
  lpm_pkg::lpm_cfg_s c;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, block and host
  always #50 sys_clk_i = ~sys_clk_i;

  lpm_mode_ctrl #(.FS_FILTER_CYC(8), .OT_DELAY_CYC(20)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_wr_valid_i(spi_wr_valid_i),
    .spi_wr_kind_i(spi_wr_kind_i), .spi_wr_accept_o(spi_wr_accept_o),
    .spi_fail_set_o(spi_fail_set_o), .cfg_i(cfg_i), .park_brake_i(park_brake_i),
    .fail_i(fail_i), .restart_req_i(1'b0), .restart_done_i(restart_done_i),
    .can_wake_i(src[0]), .wake_inputs_i({2'b00, src[1]}), .ls_short_i(src[2]),
    .ov_brake_i(src[3]), .regulator_overtemp_shutdown_i(overtemp), .int_mask_i(int_mask_i),
    .wake_flags_pending_i(wake_flags_pending_i), .wake_flags_clr_o(wake_flags_clr_o),
    .mode_o(mode_o), .func_o(func_o), .ls_brake_o(ls_brake_o),
    .reset_out_n_o(reset_out_n_o), .int_n_o(int_n_o));

  lpm_host host (
    .sys_clk_i(sys_clk_i), .spi_wr_accept_i(spi_wr_accept_o), .spi_fail_set_i(spi_fail_set_o),
    .spi_wr_valid_o(spi_wr_valid_i), .spi_wr_kind_o(spi_wr_kind_i), .cfg_o(cfg_i));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [10:0] summ(input lpm_pkg::lpm_func_s f);
    return {f.main_regulator, f.wd_en, f.hs_en, f.bd_en, f.cp_en, f.csa_en, f.can_mode,
            f.cyc_sense_en, f.cyc_wake_en};
  endfunction

  task step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #10;
  endtask

  // Bounded wait for a mode, reports cycles spent
  task wait_mode(input lpm_pkg::lpm_mode_e m, input int max, output int n);
    n = 0;
    while (mode_o !== m && n < max) begin
      step(1);
      n++;
    end
  endtask

  task go_normal();
    int n;
    step(1);
    restart_done_i = 1'b1;
    step(1);
    restart_done_i = 1'b0;
    wait_mode(lpm_pkg::MODE_NORMAL, 5, n);
    `CHK(mode_o, lpm_pkg::MODE_NORMAL)
  endtask

  // Raise one wake source in Stop and look for the interrupt pulse
  task wake_int(input int s, input logic masked);
    step(1);
    src[s] = 1'b1;
    step(3);
    `CHK(int_n_o, masked)
    step(1);
    `CHK(int_n_o, 1'b1)
    `CHK(mode_o, lpm_pkg::MODE_STOP)
    src[s] = 1'b0;
    step(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset();
    `CHK(mode_o, lpm_pkg::MODE_RESTART)
    `CHK(reset_out_n_o, 1'b0)
    `CHK(int_n_o, 1'b1)
    go_normal();
  endtask

  task automatic t_stop();
    lpm_pkg::lpm_cmd_e k[5] = '{lpm_pkg::CMD_CFG_WRITE, lpm_pkg::CMD_STOP,
                                lpm_pkg::CMD_WD_REFRESH, lpm_pkg::CMD_STATUS_CLR, lpm_pkg::CMD_SOFT_RESET};
    c = '{wd_en: 1, hs_en: 1, bd_en: 1, cp_en: 1, csa_en: 1, can_mode: lpm_pkg::CAN_ACTIVE,
          cyc_sense_en: 1, cyc_wake_en: 0, wk_wake_en: 3'h1};
    host.configure(c);
    wake_flags_pending_i = 1'b1;
    host.send(lpm_pkg::CMD_STOP);
    wake_flags_pending_i = 1'b0;
    `CHK(mode_o, lpm_pkg::MODE_STOP)
    `CHK(int_n_o, 1'b0)
    `CHK(summ(func_o), {lpm_pkg::REG_LOW_POWER, 5'b11000, lpm_pkg::CAN_ACTIVE, 2'b10})
    park_brake_i = 1'b1;
    step(1);
    `CHK(ls_brake_o, 1'b1)
    park_brake_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      host.send(k[i]);
      `CHK({host.last_accept, host.last_fail}, (i < 2) ? 2'b01 : 2'b10)
      `CHK(mode_o, lpm_pkg::MODE_STOP)
    end
    for (int s = 0; s < 4; s++) wake_int(s, 1'b0);
    int_mask_i = 4'hf;
    wake_int(0, 1'b1);
    int_mask_i = 4'h0;
    // Leave Stop by command, then re-enter with no pending flags
    host.send(lpm_pkg::CMD_NORMAL);
    `CHK({host.last_accept, host.last_fail}, 2'b10)
    `CHK(mode_o, lpm_pkg::MODE_NORMAL)
    host.send(lpm_pkg::CMD_STOP);
    `CHK(int_n_o, 1'b1)
    `CHK(mode_o, lpm_pkg::MODE_STOP)
  endtask

  task t_stop_sleep();
    src[0] = 1'b1;
    step(4);
    host.send(lpm_pkg::CMD_SLEEP);
    `CHK({host.last_accept, host.last_fail}, 2'b01)
    `CHK(mode_o, lpm_pkg::MODE_RESTART)
    `CHK(reset_out_n_o, 1'b0)
    `CHK(summ(func_o), {lpm_pkg::REG_ON, 5'b00000, lpm_pkg::CAN_WOKEN, 2'b00})
    src[0] = 1'b0;
    go_normal();
  endtask

  task t_sleep();
    int n;
    c = '{wd_en: 1, hs_en: 1, bd_en: 1, cp_en: 1, csa_en: 1, can_mode: lpm_pkg::CAN_WAKE_CAP,
          cyc_sense_en: 0, cyc_wake_en: 1, wk_wake_en: 3'h1};
    host.configure(c);
    host.send(lpm_pkg::CMD_SLEEP);
    `CHK(mode_o, lpm_pkg::MODE_SLEEP)
    `CHK(summ(func_o), {lpm_pkg::REG_OFF, 5'b01000, lpm_pkg::CAN_WAKE_CAP, 2'b01})
    park_brake_i = 1'b1;
    step(1);
    `CHK(ls_brake_o, 1'b1)
    park_brake_i = 1'b0;
    src[1] = 1'b1;
    wait_mode(lpm_pkg::MODE_RESTART, 8, n);
    `CHK(mode_o, lpm_pkg::MODE_RESTART)
    src[1] = 1'b0;
    go_normal();
  endtask

  task enter_fs();
    step(1);
    fail_i = 1'b1;
    step(1);
    fail_i = 1'b0;
    `CHK(mode_o, lpm_pkg::MODE_FS)
    `CHK(wake_flags_clr_o, 1'b1)
  endtask

  task t_failsafe();
    int n;
    park_brake_i = 1'b1;
    enter_fs();
    `CHK(summ(func_o), {lpm_pkg::REG_OFF, 5'b00000, lpm_pkg::CAN_WAKE_CAP, 2'b00})
    `CHK({func_o.can_wake_src, func_o.wk_wake_src}, {1'b1, c.wk_wake_en})
    `CHK(ls_brake_o, 1'b0)
    step(1);
    `CHK(wake_flags_clr_o, 1'b0)
    step(30);
    `CHK(mode_o, lpm_pkg::MODE_FS)
    park_brake_i = 1'b0;
    src[0] = 1'b1;
    step(3);
    src[0] = 1'b0;
    wait_mode(lpm_pkg::MODE_RESTART, 4, n);
    `CHK(mode_o, lpm_pkg::MODE_RESTART)
    go_normal();
    enter_fs();
    src[1] = 1'b1;
    step(3);
    src[1] = 1'b0;
    wait_mode(lpm_pkg::MODE_RESTART, 12, n);
    `CHK(n >= 4 && n <= 8, 1'b1)
    `CHK(mode_o, lpm_pkg::MODE_RESTART)
    go_normal();
  endtask

  task t_overtemp();
    int n;
    step(1);
    overtemp = 1'b1;
    wait_mode(lpm_pkg::MODE_FS, 5, n);
    `CHK(mode_o, lpm_pkg::MODE_FS)
    step(10);
    overtemp = 1'b0;
    step(18);
    `CHK(mode_o, lpm_pkg::MODE_FS)
    wait_mode(lpm_pkg::MODE_RESTART, 10, n);
    `CHK(mode_o, lpm_pkg::MODE_RESTART)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and sequencing
  task test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(100 * 3000);
    err_count++;
    test_done();
  end

  initial begin
    step(8);
    rst_i = 1'b0;
    step(3);
    t_reset();
    t_stop();
    t_stop_sleep();
    t_sleep();
    t_failsafe();
    t_overtemp();
    test_done();
  end
endmodule
